// ### src/rdac_top.sv
// reset combining, debug access gating and debug pin functions
// Notes on behaviour
// - watchdog frozen during core debug halt
// - other peripherals keep running during halt
// - debug port refused while pin reset
// - after reset five debug pins enabled
// - six pin configurations, unused become ports
// - three sources produce system reset
`timescale 1ns/10ps
`include "rdac_params.svh"
module rdac_top (
    input  wire logic               CORE_CLK_IN,
    input  wire logic               ARST_N_IN,
    input  wire logic               RESET_PIN_N_IN,
    input  wire logic               WATCHDOG_TIMER_EXPIRE_IN,
    input  wire logic               SOFTWARE_RESET_REQUEST_BIT_IN,
    input  wire logic               CORE_HALT_IN,
    input  wire logic               DEBUG_LINK_CLK_IN,
    input  wire logic               PIN_CFG_WRITE_IN,
    input  wire rdac_pkg::rdac_cfg_t PIN_CFG_IN,
    output logic                    SYS_RESET_N_OUT,
    output logic                    WATCHDOG_TIMER_RUN_OUT,
    output logic                    PERIPH_RUN_OUT,
    output logic                    DEBUG_PORT_ENABLE_OUT,
    output logic                    DEBUG_LINK_EDGE_OUT,
    output rdac_pkg::rdac_pins_s    DEBUG_PIN_ENABLE_OUT,
    output rdac_pkg::rdac_src_s     RESET_CAUSE_OUT
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_sync;
    logic [2:0] lclk_sync;
    logic       pin_n;
    logic       lclk;
    logic       lclk_prev;

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_sync <= `RDAC_SYNC_ONES;
        end else begin
            pin_sync <= {pin_sync[1:0], RESET_PIN_N_IN};
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            lclk_sync <= `RDAC_SYNC_ZEROS;
        end else begin
            lclk_sync <= {lclk_sync[1:0], DEBUG_LINK_CLK_IN};
        end
    end

    // filtered levels: change only when stages two and three agree
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_n     <= 1'b1;
            lclk      <= 1'b0;
            lclk_prev <= 1'b0;
        end else begin
            if (pin_sync[2] == pin_sync[1]) begin
                pin_n <= pin_sync[2];
            end
            if (lclk_sync[2] == lclk_sync[1]) begin
                lclk <= lclk_sync[2];
            end
            lclk_prev <= lclk;
        end
    end

    // ----------------------------------------------------------------
    // reset combining
    // ----------------------------------------------------------------
    rdac_pkg::rdac_state_e state;
    rdac_pkg::rdac_state_e next_state;
    logic [3:0]            stretch;
    logic                  any_req;

    assign any_req = !pin_n || WATCHDOG_TIMER_EXPIRE_IN || SOFTWARE_RESET_REQUEST_BIT_IN;

    always_comb begin
        next_state = state;
        case (state)
            rdac_pkg::RDAC_ST_RESET: begin
                if (!any_req) begin
                    next_state = rdac_pkg::RDAC_ST_HOLD;
                end
            end
            rdac_pkg::RDAC_ST_HOLD: begin
                if (any_req) begin
                    next_state = rdac_pkg::RDAC_ST_RESET;
                end else if (stretch == `RDAC_CNT_ONE) begin
                    next_state = rdac_pkg::RDAC_ST_RUN;
                end
            end
            rdac_pkg::RDAC_ST_RUN: begin
                if (any_req) begin
                    next_state = rdac_pkg::RDAC_ST_RESET;
                end
            end
            default: next_state = rdac_pkg::RDAC_ST_RESET;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state <= rdac_pkg::RDAC_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            stretch <= `RDAC_RST_STRETCH;
        end else if (next_state == rdac_pkg::RDAC_ST_HOLD && state != rdac_pkg::RDAC_ST_HOLD) begin
            stretch <= `RDAC_RST_STRETCH;
        end else if (state == rdac_pkg::RDAC_ST_HOLD && stretch != `RDAC_CNT_ZERO) begin
            stretch <= stretch - `RDAC_CNT_ONE;
        end
    end

    // output asserts at once, releases only on entry to run
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            SYS_RESET_N_OUT <= 1'b0;
        end else begin
            SYS_RESET_N_OUT <= (next_state == rdac_pkg::RDAC_ST_RUN);
        end
    end

    // cause taken on every cycle with a request, held until the next request
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RESET_CAUSE_OUT <= '0;
        end else if (any_req) begin
            RESET_CAUSE_OUT <= '{pin: !pin_n,
                                 watchdog_timer: WATCHDOG_TIMER_EXPIRE_IN,
                                 software_reset_request_bit: SOFTWARE_RESET_REQUEST_BIT_IN};
        end
    end

    // ----------------------------------------------------------------
    // halt handling and debug access
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            WATCHDOG_TIMER_RUN_OUT <= 1'b0;
            PERIPH_RUN_OUT         <= 1'b0;
        end else begin
            WATCHDOG_TIMER_RUN_OUT <= (next_state == rdac_pkg::RDAC_ST_RUN) && !CORE_HALT_IN;
            PERIPH_RUN_OUT         <= (next_state == rdac_pkg::RDAC_ST_RUN);
        end
    end

    // watchdog and software resets leave the debug link usable,
    // which is what lets a host stop at the reset vector
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            DEBUG_PORT_ENABLE_OUT <= 1'b0;
            DEBUG_LINK_EDGE_OUT   <= 1'b0;
        end else begin
            DEBUG_PORT_ENABLE_OUT <= pin_sync[2] && pin_sync[1] && pin_n;
            DEBUG_LINK_EDGE_OUT   <= pin_n && lclk && !lclk_prev;
        end
    end

    // ----------------------------------------------------------------
    // debug pin functions
    // ----------------------------------------------------------------
    function automatic rdac_pkg::rdac_pins_s cfg_pins(input rdac_pkg::rdac_cfg_t cfg);
        rdac_pkg::rdac_pins_s p;
        p = `RDAC_PINS_NONE;
        case (cfg)
            `RDAC_CFG_JTAG_SW:      p = `RDAC_PINS_AFTER_RESET;
            `RDAC_CFG_JTAG_NO_TRST: begin
                p = `RDAC_PINS_AFTER_RESET;
                p[`RDAC_PIN_TRST] = 1'b0;
            end
            `RDAC_CFG_JTAG_TRACE:   p = ~`RDAC_PINS_NONE;
            `RDAC_CFG_SW: begin
                p[`RDAC_PIN_TCK] = 1'b1;
                p[`RDAC_PIN_TMS] = 1'b1;
            end
            `RDAC_CFG_SW_VIEWER: begin
                p[`RDAC_PIN_TCK] = 1'b1;
                p[`RDAC_PIN_TMS] = 1'b1;
                p[`RDAC_PIN_TDO] = 1'b1;
            end
            default:                p = `RDAC_PINS_NONE;
        endcase
        return p;
    endfunction

    // debug pins restored on any reset
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            DEBUG_PIN_ENABLE_OUT <= `RDAC_PINS_AFTER_RESET;
        end else if (next_state != rdac_pkg::RDAC_ST_RUN) begin
            DEBUG_PIN_ENABLE_OUT <= `RDAC_PINS_AFTER_RESET;
        end else if (PIN_CFG_WRITE_IN) begin
            DEBUG_PIN_ENABLE_OUT <= cfg_pins(PIN_CFG_IN);
        end
    end
endmodule // rdac_top

// ### src/rdac_params.svh
// constants for the reset and debug access controller
`ifndef RDAC_PARAMS_SVH
`define RDAC_PARAMS_SVH
// ----------------------------------------------------------------
// pin configuration codes
// ----------------------------------------------------------------
`define RDAC_CFG_JTAG_SW       3'h0
`define RDAC_CFG_JTAG_NO_TRST  3'h1
`define RDAC_CFG_JTAG_TRACE    3'h2
`define RDAC_CFG_SW            3'h3
`define RDAC_CFG_SW_VIEWER     3'h4
`define RDAC_CFG_NONE          3'h5
// ----------------------------------------------------------------
// pin enable bit positions
// ----------------------------------------------------------------
`define RDAC_PIN_TRST          0
`define RDAC_PIN_TDI           1
`define RDAC_PIN_TDO           2
`define RDAC_PIN_TCK           3
`define RDAC_PIN_TMS           4
`define RDAC_PIN_TDATA         5
`define RDAC_PIN_TCLK          6
`define RDAC_PINS_AFTER_RESET  7'h1F
`define RDAC_PINS_NONE         7'h00
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RDAC_SYNC_ONES         3'h7
`define RDAC_SYNC_ZEROS        3'h0
`define RDAC_RST_STRETCH       4'hC
`define RDAC_CNT_ZERO          4'h0
`define RDAC_CNT_ONE           4'h1
`endif

// ### src/rdac_pkg.sv
// types for the reset and debug access controller
package rdac_pkg;
    typedef logic [2:0] rdac_cfg_t;
    typedef struct packed {
        logic trace_clock_pin;
        logic trace_data_pins;
        logic tms_swdio;
        logic tck_swclk;
        logic tdo_serial_viewer_output;
        logic tdi;
        logic trst;
    } rdac_pins_s;
    typedef struct packed {
        logic pin;
        logic watchdog_timer;
        logic software_reset_request_bit;
    } rdac_src_s;
    typedef enum logic [2:0] {
        RDAC_ST_RESET = 3'b001,
        RDAC_ST_HOLD  = 3'b010,
        RDAC_ST_RUN   = 3'b100
    } rdac_state_e;
endpackage

// ### verification/rdac_checker.sv
// assertions on the reset and debug access controller ports
`timescale 1ns/10ps
`include "rdac_params.svh"
module rdac_checker (
    input wire logic                 CORE_CLK_IN,
    input wire logic                 ARST_N_IN,
    input wire logic                 RESET_PIN_N_IN,
    input wire logic                 WATCHDOG_TIMER_EXPIRE_IN,
    input wire logic                 SOFTWARE_RESET_REQUEST_BIT_IN,
    input wire logic                 CORE_HALT_IN,
    input wire logic                 SYS_RESET_N_OUT,
    input wire logic                 WATCHDOG_TIMER_RUN_OUT,
    input wire logic                 PERIPH_RUN_OUT,
    input wire logic                 DEBUG_PORT_ENABLE_OUT,
    input wire logic                 DEBUG_LINK_EDGE_OUT,
    input wire rdac_pkg::rdac_pins_s DEBUG_PIN_ENABLE_OUT,
    input wire rdac_pkg::rdac_src_s  RESET_CAUSE_OUT
);
    // ----
    // quiet time since last request
    // ----
    logic [4:0] quiet;
    wire        req = WATCHDOG_TIMER_EXPIRE_IN | SOFTWARE_RESET_REQUEST_BIT_IN | !RESET_PIN_N_IN;
    // saturates so long runs never wrap
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) quiet <= 5'h00;
        else if (req) quiet <= 5'h00;
        else if (quiet != 5'h1F) quiet <= quiet + 5'h01;
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    property p_frz; CORE_HALT_IN && $past(CORE_HALT_IN) |-> !WATCHDOG_TIMER_RUN_OUT; endproperty
    a_frz: assert property (p_frz) else $error("watchdog ran in halt");
    property p_res;
        SYS_RESET_N_OUT && $past(SYS_RESET_N_OUT) && !$past(CORE_HALT_IN) |-> WATCHDOG_TIMER_RUN_OUT;
    endproperty
    a_res: assert property (p_res) else $error("watchdog not resumed");
    property p_per; SYS_RESET_N_OUT && $past(SYS_RESET_N_OUT) |-> PERIPH_RUN_OUT; endproperty
    a_per: assert property (p_per) else $error("peripherals stopped");
    property p_pin; !RESET_PIN_N_IN [*7] |-> !DEBUG_PORT_ENABLE_OUT && !DEBUG_LINK_EDGE_OUT; endproperty
    a_pin: assert property (p_pin) else $error("debug link open in pin reset");
    property p_dfl; !SYS_RESET_N_OUT |-> DEBUG_PIN_ENABLE_OUT == `RDAC_PINS_AFTER_RESET; endproperty
    a_dfl: assert property (p_dfl) else $error("debug pins wrong in reset");
    property p_wd; WATCHDOG_TIMER_EXPIRE_IN |=> !SYS_RESET_N_OUT && RESET_CAUSE_OUT.watchdog_timer;
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog reset missing");
    property p_sw; SOFTWARE_RESET_REQUEST_BIT_IN |=> !SYS_RESET_N_OUT; endproperty
    a_sw: assert property (p_sw) else $error("software reset missing");
    property p_prs; !RESET_PIN_N_IN [*7] |-> !SYS_RESET_N_OUT; endproperty
    a_prs: assert property (p_prs) else $error("pin reset missing");
    property p_str; $rose(SYS_RESET_N_OUT) |-> quiet >= 5'h0B; endproperty
    a_str: assert property (p_str) else $error("release too early");
    property p_rel; quiet == 5'h14 |-> SYS_RESET_N_OUT; endproperty
    a_rel: assert property (p_rel) else $error("release too late");
    c_wd: cover property (WATCHDOG_TIMER_EXPIRE_IN);
    c_pin: cover property (!RESET_PIN_N_IN [*7]);
    c_edge: cover property (DEBUG_LINK_EDGE_OUT);
endmodule // rdac_checker
bind rdac_top rdac_checker rdac_checker_inst (.*);

// ### verification/rdac_probe_model.sv
// board reset circuit and debug probe clock
`timescale 1ns/10ps
module rdac_probe_model (
    input  wire logic hold_in,
    input  wire logic frame_in,
    output logic      reset_pin_n_out,
    output logic      link_clk_out
);
    logic clk_q = 1'b0;
    assign reset_pin_n_out = !hold_in;
    // clock only in frames
    // whole periods from frame start, so no half bit at the end
    always @(posedge frame_in) begin
        while (frame_in) begin
            #160 clk_q = 1'b1;
            #160 clk_q = 1'b0;
        end
    end
    assign link_clk_out = clk_q;
endmodule // rdac_probe_model

// ### verification/rdac_top_tb.sv
// self-checking bench for the reset and debug access controller
`timescale 1ns/10ps
`include "rdac_params.svh"
module rdac_top_tb;
    logic clk = 1'b0, arst_n = 1'b0, hold = 1'b1, frame = 1'b0;
    logic wd = 1'b0, sw = 1'b0, halt = 1'b0, wr = 1'b0;
    logic [2:0] cfg = 3'h0;
    wire pin_n, lclk, sys_n, wd_run, p_run, dbg_en, lnk_edge;
    rdac_pkg::rdac_pins_s pins;
    rdac_pkg::rdac_src_s cause;
    int n_errors = 0, checks_done = 0, k, e = 0, e0, c;
    initial forever #20 clk = ~clk;
    // sampled away from the launching edge
    always @(negedge clk) if (lnk_edge === 1'b1) e++;
    rdac_probe_model rdac_probe_model_inst (.hold_in(hold), .frame_in(frame),
        .reset_pin_n_out(pin_n), .link_clk_out(lclk));
    rdac_top rdac_top_inst (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .RESET_PIN_N_IN(pin_n),
        .WATCHDOG_TIMER_EXPIRE_IN(wd), .SOFTWARE_RESET_REQUEST_BIT_IN(sw),
        .CORE_HALT_IN(halt), .DEBUG_LINK_CLK_IN(lclk), .PIN_CFG_WRITE_IN(wr),
        .PIN_CFG_IN(cfg), .SYS_RESET_N_OUT(sys_n), .WATCHDOG_TIMER_RUN_OUT(wd_run),
        .PERIPH_RUN_OUT(p_run), .DEBUG_PORT_ENABLE_OUT(dbg_en),
        .DEBUG_LINK_EDGE_OUT(lnk_edge), .DEBUG_PIN_ENABLE_OUT(pins), .RESET_CAUSE_OUT(cause));
    // ----
    // helpers
    // ----
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_up;
        k = 0;
        while (sys_n !== 1'b1 && k < 60) begin
            cyc(1);
            k++;
        end
        if (k == 60) begin
            n_errors++;
            conclude();
        end
    endtask
    function automatic logic [6:0] exp_pins(input logic [2:0] v);
        case (v)
            3'h0: return 7'h1F;
            3'h1: return 7'h1E;
            3'h2: return 7'h7F;
            3'h3: return 7'h18;
            3'h4: return 7'h1C;
            default: return 7'h00;
        endcase
    endfunction
    // ----
    // tests
    // ----
    initial begin
        void'($urandom(32'h51DD65F6));
        cyc(12);
        arst_n = 1'b1;
        e0 = e;
        frame = 1'b1;
        cyc(62);
        frame = 1'b0;
        cyc(8);
        chk(dbg_en, 1'b0);
        chk(e - e0, 0);
        chk(pins, `RDAC_PINS_AFTER_RESET);
        hold = 1'b0;
        wait_up();
        e0 = e;
        frame = 1'b1;
        cyc(62);
        frame = 1'b0;
        cyc(8);
        chk(e - e0, 8);
        $display("test link done");
        wr = 1'b1;
        for (c = 0; c < 28; c++) begin
            cfg = (c < 8) ? c[2:0] : 3'($urandom);
            cyc(1);
            chk(pins, exp_pins(cfg));
        end
        wr = 1'b0;
        repeat (40) begin
            halt = 1'($urandom);
            cyc(1);
            chk({wd_run, p_run}, {~halt, 1'b1});
        end
        $display("test config and halt done");
        for (c = 0; c < 2; c++) begin
            cfg = `RDAC_CFG_NONE;
            wr = 1'b1;
            cyc(1);
            wr = 1'b0;
            wd = (c == 0);
            sw = (c == 1);
            cyc(1);
            wd = 1'b0;
            sw = 1'b0;
            chk({sys_n, dbg_en, cause}, {2'b01, (c == 0) ? 3'h2 : 3'h1});
            chk(pins, `RDAC_PINS_AFTER_RESET);
            wait_up();
            chk(k, 7'(`RDAC_RST_STRETCH) + 7'h01);
        end
        hold = 1'b1;
        cyc(12);
        chk({sys_n, dbg_en, cause}, 5'h04);
        hold = 1'b0;
        wait_up();
        sw = 1'b1;
        cyc(1);
        sw = 1'b0;
        chk({sys_n, cause}, 4'h1);
        wait_up();
        chk(pins, `RDAC_PINS_AFTER_RESET);
        $display("test resets done");
        conclude();
    end
endmodule // rdac_top_tb
